// ---- ztg_pkg.sv ----
`default_nettype none
package ztg_pkg;

  // Breaker slots of the double-ended substation.
  localparam int NB    = 7;
  localparam int B_MAIN1 = 0;
  localparam int B_MAIN2 = 1;
  localparam int B_TIE = 2;
  localparam int B_F1A = 3;
  localparam int B_F1B = 4;
  localparam int B_F2A = 5;
  localparam int B_F2B = 6;
  localparam int NZ    = 2;

  // Feeders hanging on each bus.
  localparam logic [NB-1:0] ZONE0_FDR = 7'h18;
  localparam logic [NB-1:0] ZONE1_FDR = 7'h60;

  // Sampling and arithmetic widths.
  localparam int SW     = 16;
  localparam int RW     = SW + 2;
  localparam int ZW     = RW + 1;
  localparam int SQW    = 2 * ZW;
  localparam int SPC    = 64;
  localparam int HALF   = SPC / 2;
  localparam int IDX_W  = $clog2(HALF);
  localparam int ACCW   = SQW + IDX_W;
  localparam logic [IDX_W-1:0] IDX_LAST = 5'h1F;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PICKUP = 8'h04;
  localparam logic [7:0] A_DELAY  = 8'h08;
  localparam logic [7:0] A_FDRGF  = 8'h0C;
  localparam logic [7:0] A_OCLIM  = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_EVCNT  = 8'h18;
  localparam logic [7:0] A_MS0    = 8'h1C;
  localparam logic [7:0] A_MS1    = 8'h20;
  localparam logic [7:0] A_VTSEL  = 8'h24;
  localparam logic [7:0] A_TRIP   = 8'h28;

  // Control fields and reset values.
  localparam int CTRL_EN    = 0;
  localparam int CTRL_MAINT = 1;
  localparam int CTRL_CLR   = 2;
  localparam logic [1:0]  CTRL_RST   = 2'h1;
  localparam logic [31:0] PICKUP_RST = 32'hFFFFFFFF;
  localparam logic [15:0] DELAY_RST  = 16'h0404;
  localparam logic [15:0] FDRGF_RST  = 16'h7FFF;
  localparam logic [15:0] OCLIM_RST  = 16'h7FFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Voltage-transformer choice per breaker.
  typedef enum logic [1:0] {
    VT_NONE = 2'b00,
    VT_ONE  = 2'b01,
    VT_TWO  = 2'b10
  } ztg_vt_e;

endpackage
`default_nettype wire

// ---- ztg_top.sv ----
// Contract
// - Unpowered or maintenance zone reports topology 0.
// - Zone fed from first main reports 1.
// - Zone fed from second main reports 2.
// - All three closed gives topology 3.
// - One 0-3 number drives all zone settings.
// - Transformer choice follows breaker role and topology.
// - Bad link or test mode disables zones.
// - Per-breaker overcurrent stays on for healthy nodes.
// - Ground fault covers up to four sources.
// - Zone sum uses only mains and tie.
// - Zone fault trips feeding sources, zone delay.
// - Feeder with fault current takes the trip.
// - Residual is sum of four currents.
// - Sixty-four samples per cycle, sample-wise sums.
// - Half-cycle mean square of zone sum.
// - Half-cycle count scales with zone delay.
// - Topology breaker change records an event.
// - Thirty breakers, eight topology breakers maximum.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ztg_top
  import ztg_pkg::*;
(
  // Clock and reset.
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Breaker sensing nodes.
  input  wire logic                   smp_valid,
  input  wire logic [NB-1:0][SW-1:0]  cur_a,
  input  wire logic [NB-1:0][SW-1:0]  cur_b,
  input  wire logic [NB-1:0][SW-1:0]  cur_c,
  input  wire logic [NB-1:0][SW-1:0]  cur_n,
  input  wire logic [NB-1:0]          brk_closed,
  input  wire logic [NB-1:0]          node_test,
  input  wire logic [NB-1:0]          node_comm_ok,
  // Protection results.
  output logic [NB-1:0]               trip,
  output logic [NB-1:0][1:0]          vt_sel,
  output logic [1:0]                  topo_z0,
  output logic [1:0]                  topo_z1,
  output logic                        zone_prot_en,
  output logic [NZ-1:0]               zone_fault,
  output logic                        state_event
);

  function automatic logic signed [RW-1:0] sx(input logic [SW-1:0] v);
    sx = {{2{v[SW-1]}}, v};
  endfunction

  function automatic logic [RW-1:0] mag(input logic signed [RW-1:0] v);
    mag = v[RW-1] ? RW'(-v) : RW'(v);
  endfunction

  // Zone number from own main, far main and tie; own_code is 1 or 2.
  function automatic logic [1:0] topo(input logic own, input logic far,
                                      input logic tie, input logic [1:0] own_code);
    if (own && far && tie)
      topo = 2'd3;
    else if (own)
      topo = own_code;
    else if (far && tie)
      topo = 2'd3 - own_code;
    else
      topo = 2'd0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
  endfunction

  function automatic logic [31:0] sat32(input logic [SQW-1:0] v);
    sat32 = (|v[SQW-1:32]) ? 32'hFFFFFFFF : v[31:0];
  endfunction

  // Registers.
  logic [1:0]             ctrl_ff;
  logic [31:0]            pickup_ff;
  logic [15:0]            delay_ff;
  logic [15:0]            fdrgf_ff;
  logic [15:0]            oclim_ff;
  logic [31:0]            evcnt_ff;
  logic [NZ-1:0][SQW-1:0] ms_ff;
  logic [NZ-1:0][ACCW-1:0] acc_ff;
  logic [NZ-1:0][7:0]     cnt_ff;
  logic [NZ-1:0][ZW-1:0]  zs_ff;
  logic [IDX_W-1:0]       idx_ff;
  logic                   s1v_ff;
  logic                   s1last_ff;
  logic [NB-1:0]          fhit_ff;
  logic [NB-1:0]          fgf_ff;
  logic [NB-1:0]          ochit_ff;
  logic [2:0]             tb_prev_ff;
  logic                   tb_seen_ff;
  logic                   aw_got_ff;
  logic                   w_got_ff;
  logic [7:0]             aw_addr_ff;
  logic [31:0]            wdata_ff;
  logic [3:0]             wstrb_ff;
  logic                   zen_ff;

  // Topology from the three breakers; maintenance forces zero.
  wire       maint  = ctrl_ff[CTRL_MAINT];
  wire [1:0] t0     = maint ? 2'd0 : topo(brk_closed[B_MAIN1], brk_closed[B_MAIN2],
                                          brk_closed[B_TIE], 2'd1);
  wire [1:0] t1     = maint ? 2'd0 : topo(brk_closed[B_MAIN2], brk_closed[B_MAIN1],
                                          brk_closed[B_TIE], 2'd2);
  // The tie sees whichever bus is live; topology 3 selects the first transformer.
  wire [1:0] t_tie  = (t1 != 2'd0) ? t1 : t0;

  // Any faulty link or test node drops every zone algorithm.
  wire zen = ctrl_ff[CTRL_EN] & (&node_comm_ok) & ~(|node_test);

  // Event on a change of a topology breaker, ignoring the first look.
  wire [2:0] tb   = brk_closed[2:0];
  wire       tchg = tb_seen_ff && (tb != tb_prev_ff);

  // Stage 1 arithmetic on the incoming sample set.
  logic signed [RW-1:0] res [NB];
  logic [NB-1:0]        fhit;
  logic [NB-1:0]        ochit;
  logic [NB-1:0][1:0]   vt;
  always_comb
  begin
    for (int i = 0; i < NB; i++)
    begin
      res[i]   = sx(cur_a[i]) + sx(cur_b[i]) + sx(cur_c[i]) + sx(cur_n[i]);
      fhit[i]  = mag(res[i]) > {2'b00, fdrgf_ff};
      ochit[i] = (mag(sx(cur_a[i])) > {2'b00, oclim_ff}) ||
                 (mag(sx(cur_b[i])) > {2'b00, oclim_ff}) ||
                 (mag(sx(cur_c[i])) > {2'b00, oclim_ff});
    end
    vt[B_MAIN1] = VT_ONE;
    vt[B_MAIN2] = VT_TWO;
    vt[B_TIE] = (t_tie == 2'd0) ? VT_NONE : (t_tie == 2'd3) ? VT_ONE : VT_TWO;
    for (int i = B_F1A; i < NB; i++)
    begin
      logic [1:0] tz;
      tz = ZONE0_FDR[i] ? t0 : t1;
      unique case (tz)
        2'd0:    vt[i] = VT_NONE;
        2'd1:    vt[i] = VT_ONE;
        2'd2:    vt[i] = VT_TWO;
        2'd3:    vt[i] = ZONE0_FDR[i] ? VT_ONE : VT_TWO;
      endcase
    end
  end

  // Only the bounding mains and tie enter the sums; tie current is
  // taken positive from bus 0 toward bus 1.
  wire signed [ZW-1:0] zs0 = ZW'(res[B_MAIN1]) - ZW'(res[B_TIE]);
  wire signed [ZW-1:0] zs1 = ZW'(res[B_MAIN2]) + ZW'(res[B_TIE]);

  // Stage 2: square, accumulate, and judge at the half-cycle end.
  logic [NZ-1:0][ACCW-1:0] tot;
  logic [NZ-1:0][SQW-1:0]  msn;
  logic [NZ-1:0][7:0]      nxt_cnt;
  logic [NZ-1:0]           zflt;
  logic [NB-1:0]           zset;
  logic [NB-1:0]           fcur;
  logic [NB-1:0]           src [NZ];
  logic [NB-1:0]           zfdr [NZ];
  always_comb
  begin
    fcur    = fgf_ff | fhit_ff;
    src[0]  = '0;
    src[1]  = '0;
    src[0][B_MAIN1] = brk_closed[B_MAIN1];
    src[0][B_TIE]   = brk_closed[B_TIE] & brk_closed[B_MAIN2];
    src[1][B_MAIN2] = brk_closed[B_MAIN2];
    src[1][B_TIE]   = brk_closed[B_TIE] & brk_closed[B_MAIN1];
    zfdr[0] = ZONE0_FDR;
    zfdr[1] = ZONE1_FDR;
    zset    = '0;
    for (int z = 0; z < NZ; z++)
    begin
      logic [8:0] lim;
      logic       over;
      tot[z] = acc_ff[z] + ACCW'($signed(zs_ff[z]) * $signed(zs_ff[z]));
      msn[z] = SQW'(tot[z] >> IDX_W);
      lim    = (delay_ff[8*z +: 8] == 8'h00) ? 9'd1 : {1'b0, delay_ff[8*z +: 8]};
      over   = msn[z] > {{(SQW-32){1'b0}}, pickup_ff};
      zflt[z] = 1'b0;
      nxt_cnt[z] = cnt_ff[z];
      if (!zen_ff || (z == 0 ? topo_z0 : topo_z1) == 2'd0)
        nxt_cnt[z] = 8'h00;
      else if (s1v_ff && s1last_ff)
      begin
        if (!over)
          nxt_cnt[z] = 8'h00;
        else if ({1'b0, cnt_ff[z]} + 9'd1 >= lim)
        begin
          zflt[z]    = 1'b1;
          nxt_cnt[z] = 8'h00;
          if (|(fcur & zfdr[z]))
            zset = zset | (fcur & zfdr[z]);
          else
            zset = zset | src[z];
        end
        else
          nxt_cnt[z] = cnt_ff[z] + 8'h01;
      end
    end
  end

  // Overcurrent per breaker is independent of the zone enable.
  wire [NB-1:0] oc_set = s1v_ff ? (ochit_ff & node_comm_ok) : '0;

  // Bus handshakes and decode.
  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire ar_hs  = s_axi_arvalid & s_axi_arready;
  wire do_wr  = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_map = (aw_addr_ff <= A_OCLIM) && (aw_addr_ff[1:0] == 2'b00);
  wire clr    = do_wr && (aw_addr_ff == A_CTRL) && wstrb_ff[0] && wdata_ff[CTRL_CLR];
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      A_CTRL:   rd_word = {30'h0, ctrl_ff};
      A_PICKUP: rd_word = pickup_ff;
      A_DELAY:  rd_word = {16'h0, delay_ff};
      A_FDRGF:  rd_word = {16'h0, fdrgf_ff};
      A_OCLIM:  rd_word = {16'h0, oclim_ff};
      A_STATUS: rd_word = {25'h0, zone_fault, zone_prot_en, topo_z1, topo_z0};
      A_EVCNT:  rd_word = evcnt_ff;
      A_MS0:    rd_word = sat32(ms_ff[0]);
      A_MS1:    rd_word = sat32(ms_ff[1]);
      A_VTSEL:  rd_word = {18'h0, vt_sel};
      A_TRIP:   rd_word = {25'h0, trip};
      default:
      begin
        rd_word = 32'h0;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // Bus slave state; one write and one read under way at most.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
    end
    else
    begin
      s_axi_awready <= ~(aw_hs | (aw_got_ff & ~do_wr));
      s_axi_wready  <= ~(w_hs | (w_got_ff & ~do_wr));
      s_axi_arready <= ~(ar_hs | (s_axi_rvalid & ~s_axi_rready));
      aw_got_ff     <= aw_hs | (aw_got_ff & ~do_wr);
      w_got_ff      <= w_hs | (w_got_ff & ~do_wr);
      if (aw_hs)
        aw_addr_ff <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Software-writable settings.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff   <= CTRL_RST;
      pickup_ff <= PICKUP_RST;
      delay_ff  <= DELAY_RST;
      fdrgf_ff  <= FDRGF_RST;
      oclim_ff  <= OCLIM_RST;
    end
    else if (do_wr)
    begin
      if (aw_addr_ff == A_CTRL)
        ctrl_ff <= wstrb_ff[0] ? wdata_ff[1:0] : ctrl_ff;
      if (aw_addr_ff == A_PICKUP)
        pickup_ff <= merge(pickup_ff, wdata_ff, wstrb_ff);
      if (aw_addr_ff == A_DELAY)
        delay_ff <= 16'(merge({16'h0, delay_ff}, wdata_ff, wstrb_ff));
      if (aw_addr_ff == A_FDRGF)
        fdrgf_ff <= 16'(merge({16'h0, fdrgf_ff}, wdata_ff, wstrb_ff));
      if (aw_addr_ff == A_OCLIM)
        oclim_ff <= 16'(merge({16'h0, oclim_ff}, wdata_ff, wstrb_ff));
    end
  end

  // Sample pipeline and half-cycle accumulators.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idx_ff    <= '0;
      s1v_ff    <= 1'b0;
      s1last_ff <= 1'b0;
      zs_ff     <= '0;
      fhit_ff   <= '0;
      ochit_ff  <= '0;
      fgf_ff    <= '0;
      acc_ff    <= '0;
      ms_ff     <= '0;
      cnt_ff    <= '0;
      zen_ff    <= 1'b0;
    end
    else
    begin
      zen_ff    <= zen;
      s1v_ff    <= smp_valid;
      cnt_ff    <= nxt_cnt;
      if (smp_valid)
      begin
        idx_ff    <= idx_ff + 1'b1;
        s1last_ff <= (idx_ff == IDX_LAST);
        zs_ff     <= {zs1, zs0};
        fhit_ff   <= fhit;
        ochit_ff  <= ochit;
      end
      if (s1v_ff && s1last_ff)
      begin
        ms_ff  <= msn;
        acc_ff <= '0;
        fgf_ff <= '0;
      end
      else if (s1v_ff)
      begin
        acc_ff <= tot;
        fgf_ff <= fcur;
      end
    end
  end

  // Outputs: topology, transformer choice, trips and events.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      topo_z0      <= 2'd0;
      topo_z1      <= 2'd0;
      vt_sel       <= '0;
      trip         <= '0;
      zone_fault   <= '0;
      zone_prot_en <= 1'b0;
      state_event  <= 1'b0;
      tb_prev_ff   <= 3'h0;
      tb_seen_ff   <= 1'b0;
      evcnt_ff     <= 32'h0;
    end
    else
    begin
      topo_z0      <= t0;
      topo_z1      <= t1;
      vt_sel       <= vt;
      zone_prot_en <= zen;
      // A new trip wins over a clear in the same cycle.
      trip         <= (trip & ~{NB{clr}}) | oc_set | zset;
      zone_fault   <= (zone_fault & ~{NZ{clr}}) | zflt;
      tb_prev_ff   <= tb;
      tb_seen_ff   <= 1'b1;
      state_event  <= tchg;
      if (tchg)
        evcnt_ff <= evcnt_ff + 32'h1;
    end
  end

endmodule // ztg_top
`default_nettype wire

// ---- ztg_top_unused_note_removed.sv ----
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- ztg_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ztg_checker
  import ztg_pkg::*;
(
  // Clock and reset.
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus answer and node status.
  input wire logic                s_axi_bvalid,
  input wire logic [NB-1:0]       brk_closed,
  input wire logic [NB-1:0]       node_test,
  input wire logic [NB-1:0]       node_comm_ok,
  // Results.
  input wire logic [NB-1:0]       trip,
  input wire logic [NB-1:0][1:0]  vt_sel,
  input wire logic [1:0]          topo_z0,
  input wire logic [1:0]          topo_z1,
  input wire logic                zone_prot_en,
  input wire logic [NZ-1:0]       zone_fault,
  input wire logic                state_event
);
  // Zone numbers indexed by {tie, second main, first main}, two bits each.
  localparam logic [15:0] TZ0 = 16'hE444;
  localparam logic [15:0] TZ1 = 16'hE4A0;

  function automatic logic [1:0] zt(input logic [15:0] t, input logic [2:0] b);
    return t[2*b+:2];
  endfunction

  // A feeder follows its zone, but with both mains in it keeps its own bus.
  function automatic logic [1:0] fv(input logic [1:0] t, input logic [1:0] own);
    return (t == 2'h3) ? own : t;
  endfunction

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Zero stays legal because maintenance may force it.
  chk_topo_zone0: assert property (
    $past(aresetn) |-> topo_z0 == 2'h0 || topo_z0 == zt(TZ0, $past(brk_closed[2:0])))
    else $error("zone 0 number differs from breaker states");
  chk_topo_zone1: assert property (
    $past(aresetn) |-> topo_z1 == 2'h0 || topo_z1 == zt(TZ1, $past(brk_closed[2:0])))
    else $error("zone 1 number differs from breaker states");
  chk_vt_mains: assert property (
    $past(aresetn) |-> vt_sel[0] == 2'h1 && vt_sel[1] == 2'h2)
    else $error("main transformer choice wrong");
  chk_vt_feeder: assert property (
    $past(aresetn) |-> vt_sel[B_F1A] == fv(topo_z0, 2'h1) && vt_sel[B_F2B] == fv(topo_z1, 2'h2))
    else $error("feeder transformer choice wrong");
  chk_zone_off: assert property (
    (!(&node_comm_ok) || (|node_test)) |=> !zone_prot_en)
    else $error("zone protection active with a bad node");
  chk_event_after: assert property (
    brk_closed[2:0] != $past(brk_closed[2:0]) |-> ##[1:2] state_event)
    else $error("breaker change without event");
  chk_event_cause: assert property (
    state_event |-> $past(brk_closed[2:0], 2) != $past(brk_closed[2:0], 3)
                 || $past(brk_closed[2:0]) != $past(brk_closed[2:0], 2))
    else $error("event without breaker change");
  chk_trip_hold: assert property (
    |({$past(zone_fault), $past(trip)} & ~{zone_fault, trip}) |->
      s_axi_bvalid || $past(s_axi_bvalid))
    else $error("trip or fault dropped without a clear write");
  chk_zone_trip: assert property (
    $rose(zone_fault[0]) |-> |(trip & (ZONE0_FDR | 7'h05)))
    else $error("zone 0 fault without a trip in the zone");

  // Main scenarios reached.
  cover property (state_event);
  cover property ($rose(zone_fault[0]));
  cover property ($rose(trip[B_F1A]));
  cover property ($fell(zone_prot_en));
endmodule // ztg_checker

bind ztg_top ztg_checker chk_u (.*);
`default_nettype wire

// ---- ztg_nodes.sv ----
`timescale 1ns/100ps
`default_nettype none
module ztg_nodes
  import ztg_pkg::*;
(
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Bench control.
  input  wire logic                  run,
  input  wire logic [NB-1:0][SW-1:0] amp,
  // Sample stream.
  output logic                       smp_valid,
  output logic [NB-1:0][SW-1:0]      cur_a,
  output logic [NB-1:0][SW-1:0]      cur_b,
  output logic [NB-1:0][SW-1:0]      cur_c,
  output logic [NB-1:0][SW-1:0]      cur_n
);
  logic ph_ff;
  logic sgn_ff;

  // One sample set every other cycle; the sign flips per sample like a square wave.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph_ff  <= 1'h0;
      sgn_ff <= 1'h0;
    end
    else
    begin
      ph_ff  <= run & ~ph_ff;
      sgn_ff <= sgn_ff ^ ph_ff;
    end
  end

  assign smp_valid = ph_ff;

  // Between samples every line shows the inverse of its last value, so stale data fails.
  for (genvar i = 0; i < NB; i++)
  begin : g_brk
    assign cur_a[i] = ph_ff ? (sgn_ff ? -amp[i] : amp[i]) : ~(sgn_ff ? amp[i] : -amp[i]);
    assign cur_b[i] = ph_ff ? '0 : '1;
    assign cur_c[i] = ph_ff ? '0 : '1;
    assign cur_n[i] = ph_ff ? '0 : '1;
  end
endmodule // ztg_nodes
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ztg_pkg::*;
;
  localparam logic [15:0] TZ0 = 16'hE444;
  localparam logic [15:0] TZ1 = 16'hE4A0;

  // Bench-driven inputs.
  logic                  aclk = 1'h0;
  logic                  aresetn = 1'h0;
  logic [7:0]            s_axi_awaddr = 8'h00;
  logic [7:0]            s_axi_araddr = 8'h00;
  logic [31:0]           s_axi_wdata = 32'h0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, run = 1'h0;
  logic [NB-1:0][SW-1:0] amp = '0;
  logic [NB-1:0]         brk_closed = 7'h00, node_test = 7'h00, node_comm_ok = 7'h7F;
  // Outputs of the block and the node model.
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp, topo_z0, topo_z1;
  logic [31:0]           s_axi_rdata;
  logic                  smp_valid, zone_prot_en, state_event;
  logic [NB-1:0][SW-1:0] cur_a, cur_b, cur_c, cur_n;
  logic [NB-1:0]         trip;
  logic [NB-1:0][1:0]    vt_sel;
  logic [NZ-1:0]         zone_fault;
  logic [31:0]           qd;
  logic [1:0]            rr;
  int                    num_errors = 0;
  int                    tests_run = 0;

  ztg_top dut_u (.*);
  ztg_nodes nodes_u (.*);

  // Clock of 4 ns.
  always #2 aclk = ~aclk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Four-state compare so an unknown never passes for a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // One register transfer; each channel is released only at the edge that takes it.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] rs);
    logic ad;
    logic dd;
    @(posedge aclk);
    ad = 1'h0;
    dd = ~wr;
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_arvalid <= ~wr;
    s_axi_bready  <= wr;
    s_axi_rready  <= ~wr;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (!ad && (wr ? s_axi_awready : s_axi_arready))
      begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (!dd && s_axi_wready)
      begin
        dd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do
      @(posedge aclk);
    while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    q  = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bus(1'h0, a, 32'h0, qd, rr);
    chk(qd, e);
    chk(32'(rr), 32'(er));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bus(1'h1, a, d, qd, rr);
    chk(32'(rr), 32'(er));
  endtask

  // Sends whole half-cycles only, so the block's sample count stays aligned.
  task automatic send(input int n);
    int k;
    k = 0;
    run <= 1'h1;
    while (k < n)
    begin
      @(posedge aclk);
      if (smp_valid === 1'h1)
        k++;
    end
    run <= 1'h0;
    tick(4);
  endtask

  function automatic logic [1:0] fv(input logic [1:0] t, input logic [1:0] own);
    return (t == 2'h3) ? own : t;
  endfunction

  task automatic t_regs;
    rd(A_PICKUP, PICKUP_RST, RESP_OKAY);
    rd(A_DELAY, {16'h0, DELAY_RST}, RESP_OKAY);
    rd(A_FDRGF, {16'h0, FDRGF_RST}, RESP_OKAY);
    rd(A_OCLIM, {16'h0, OCLIM_RST}, RESP_OKAY);
    rd(A_CTRL, {30'h0, CTRL_RST}, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(A_STATUS, 32'hF, RESP_SLVERR);
    $display("registers done");
  endtask

  task automatic t_topo;
    logic [1:0] z0, z1, tt, tv;
    for (int i = 0; i < 8; i++)
    begin
      brk_closed[2:0] <= 3'(i);
      tick(4);
      z0 = TZ0[2*i+:2];
      z1 = TZ1[2*i+:2];
      tt = (z1 != 2'h0) ? z1 : z0;
      tv = (tt == 2'h0) ? 2'h0 : ((tt == 2'h3) ? 2'h1 : 2'h2);
      chk(32'({topo_z0, topo_z1}), 32'({z0, z1}));
      chk(32'({vt_sel[B_F1A], vt_sel[B_F2A], vt_sel[B_TIE], vt_sel[0], vt_sel[1]}),
          32'({fv(z0, 2'h1), fv(z1, 2'h2), tv, 2'h1, 2'h2}));
    end
    rd(A_EVCNT, 32'h7, RESP_OKAY);
    rd(A_STATUS, 32'h1F, RESP_OKAY);
    wr(A_CTRL, 32'h3, RESP_OKAY);
    tick(3);
    chk(32'({topo_z0, topo_z1}), 32'h0);
    wr(A_CTRL, 32'h1, RESP_OKAY);
    $display("topology done");
  endtask

  task automatic t_zone;
    brk_closed[2:0] <= 3'h3;
    wr(A_PICKUP, 32'h0000FFFF, RESP_OKAY);
    wr(A_DELAY, 32'h0102, RESP_OKAY);
    wr(A_FDRGF, 32'h0080, RESP_OKAY);
    amp[B_F1A] <= 16'h0100;
    send(32);
    rd(A_MS0, 32'h0, RESP_OKAY);
    chk(32'({trip, zone_fault}), 32'h0);
    amp[B_F1A] <= 16'h0;
    amp[0] <= 16'h0100;
    send(32);
    rd(A_MS0, 32'h00010000, RESP_OKAY);
    chk(32'(zone_fault), 32'h0);
    send(32);
    chk(32'({trip, zone_fault}), 32'({7'h01, 2'h1}));
    wr(A_CTRL, 32'h5, RESP_OKAY);
    tick(2);
    chk(32'({trip, zone_fault}), 32'h0);
    wr(A_DELAY, 32'h0101, RESP_OKAY);
    amp[B_F1A] <= 16'h0100;
    send(32);
    chk(32'(trip), 32'h08);
    wr(A_CTRL, 32'h5, RESP_OKAY);
    amp <= '0;
    $display("ground fault done");
  endtask

  // A node in test mode stops zone logic while plain overcurrent stays on.
  task automatic t_oc;
    wr(A_OCLIM, 32'h0400, RESP_OKAY);
    node_test[1] <= 1'h1;
    tick(3);
    chk(32'(zone_prot_en), 32'h0);
    node_comm_ok[B_F2A] <= 1'h0;
    amp[B_F2A] <= 16'h0800;
    amp[B_F2B] <= 16'h0800;
    // Equal main one and tie current cancels in zone 0; zone 1 sees the tie current alone.
    amp[B_MAIN1] <= 16'h0100;
    amp[B_TIE] <= 16'h0100;
    send(32);
    chk(32'({trip, zone_prot_en}), 32'({7'h40, 1'h0}));
    rd(A_MS0, 32'h0, RESP_OKAY);
    rd(A_MS1, 32'h00010000, RESP_OKAY);
    node_test[1] <= 1'h0;
    node_comm_ok[B_F2A] <= 1'h1;
    amp <= '0;
    tick(3);
    chk(32'(zone_prot_en), 32'h1);
    wr(A_CTRL, 32'h5, RESP_OKAY);
    $display("overcurrent done");
  endtask

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_topo;
    t_zone;
    t_oc;
    end_sim;
  end

  // The run needs under a thousand cycles; this limit leaves ample margin.
  initial
  begin
    #20000;
    num_errors++;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
